// [rcs_map.vh]
// constants for the reset and configuration sequencer
// assumes one 50 MHz clock that also serves as input and reference clock
`ifndef RCS_MAP_VH
`define RCS_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RCS_STATUS_OFS 8'h00
`define RCS_STRAPS_OFS 8'h04
`define RCS_CFG_WORD_OFS 8'h08
`define RCS_DSI_CFG_OFS 8'h0C

// ----------------------------------------
// status fields
// ----------------------------------------
`define RCS_ST_STATE_LSB 0
`define RCS_ST_PLL_TMO 4
`define RCS_ST_CFG_VALID 5
`define RCS_ST_CFG_DEFAULT 6
`define RCS_ST_POR_FLOW 7
`define RCS_ST_HARD 8
`define RCS_ST_SOFT 9

// ----------------------------------------
// strap fields
// ----------------------------------------
`define RCS_SP_SOURCE 0
`define RCS_SP_ROLE 1
`define RCS_SP_SYNC 2
`define RCS_SP_WIDTH 3
`define RCS_SP_SLOT_LSB 4
`define RCS_SP_BOOT_LSB 8
`define RCS_SP_WDOG 11
`define RCS_SP_CLKMODE_LSB 12
`define RCS_STRAP_W 14

// ----------------------------------------
// reset values and timing counts
// ----------------------------------------
`define RCS_DEFAULT_CFG 32'h00000000
`define RCS_POR_HOLD_CYC 1024
`define RCS_PLL_LOCK_CYC 6400
`define RCS_PLL_REF_DIV 1
`define RCS_HARD_REL_CYC 512
`define RCS_SOFT_REL_CYC 515
`define RCS_SOFT_EXT_CYC 16

`endif

// [cycle_counter.v]
// saturating cycle counter used for all sequencer delays
// assumes clear is a synchronous one-cycle request from the same clock
`timescale 1ns/1ps
module cycle_counter #(
  parameter CNT_W = 16
) (
  input wire clk,
  input wire reset,
  input wire clear,
  output reg [CNT_W-1:0] count_q
);
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      count_q <= {CNT_W{1'b0}};
    end else if (clear) begin
      count_q <= {CNT_W{1'b0}};
    end else if (count_q != {CNT_W{1'b1}}) begin
      count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end
endmodule // cycle_counter

// [reset_config_sequencer.v]
// power-on reset sequencer with strap sampling and reset configuration capture
// assumes pins arrive asynchronously, apb and the system-bus config port are on clk
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "rcs_map.vh"

// Operation
// RULE1: board holds power-on reset at least sixteen cycles
// RULE2: internal reset held 1024 cycles after release
// RULE3: pll lock expected within 6400 divided cycles
// RULE4: hard reset released 512 cycles after lock
// RULE5: soft reset released 515 cycles after lock
// RULE6: fourteen straps captured at power-on release
// RULE7: config from direct port or system bus
// RULE8: system bus config as master or slave
// RULE9: slave without written word gets default
// RULE10: hard reset always drives soft reset too
// RULE11: external soft reset seen only when idle
// RULE12: direct port after por, bus after por/hard
// RULE13: both lines held until their release counts
module reset_config_sequencer #(
  parameter CNT_W = 16,
  parameter POR_HOLD_CYC = `RCS_POR_HOLD_CYC,
  parameter PLL_LOCK_CYC = `RCS_PLL_LOCK_CYC,
  parameter PLL_REF_DIV = `RCS_PLL_REF_DIV,
  parameter SOFT_EXT_CYC = `RCS_SOFT_EXT_CYC
) (
  input wire clk,
  input wire reset,
  input wire power_on_reset_in,
  input wire [`RCS_STRAP_W-1:0] strap_in,
  input wire system_pll_lock,
  input wire hard_reset_line_in,
  output reg hard_reset_line_out,
  output reg hard_reset_line_oe,
  input wire soft_reset_line_in,
  output reg soft_reset_line_out,
  output reg soft_reset_line_oe,
  output reg internal_por_q,
  output reg [`RCS_STRAP_W-1:0] strap_q,
  output reg [31:0] cfg_word_q,
  output reg cfg_valid_q,
  output reg cfg_fetch_q,
  input wire sysbus_cfg_valid,
  input wire [31:0] sysbus_cfg_word,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr
);
  localparam S_POR = 3'd0;
  localparam S_HOLD = 3'd1;
  localparam S_PLL = 3'd2;
  localparam S_REL = 3'd3;
  localparam S_RUN = 3'd4;
  localparam S_SOFT = 3'd5;
  localparam [31:0] POR_LAST_W = POR_HOLD_CYC - 1;
  localparam [31:0] PLL_LAST_W = PLL_LOCK_CYC * PLL_REF_DIV - 1;
  localparam [31:0] HARD_LAST_W = `RCS_HARD_REL_CYC - 1;
  localparam [31:0] SOFT_LAST_W = `RCS_SOFT_REL_CYC - 1;
  localparam [31:0] EXT_LAST_W = SOFT_EXT_CYC - 1;
  localparam [CNT_W-1:0] POR_LAST = POR_LAST_W[CNT_W-1:0];
  localparam [CNT_W-1:0] PLL_LAST = PLL_LAST_W[CNT_W-1:0];
  localparam [CNT_W-1:0] HARD_LAST = HARD_LAST_W[CNT_W-1:0];
  localparam [CNT_W-1:0] SOFT_LAST = SOFT_LAST_W[CNT_W-1:0];
  localparam [CNT_W-1:0] EXT_LAST = EXT_LAST_W[CNT_W-1:0];

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg por_s1_q, por_s2_q, por_s3_q;
  reg lock_s1_q, lock_s2_q;
  reg hard_s1_q, hard_s2_q, hard_s3_q;
  reg soft_s1_q, soft_s2_q, soft_s3_q;
  reg [`RCS_STRAP_W-1:0] strap_s1_q, strap_s2_q;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      // reads as power-on asserted, so a released pin gives an edge
      por_s1_q <= 1'b0;
      por_s2_q <= 1'b0;
      por_s3_q <= 1'b0;
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
      hard_s1_q <= 1'b1;
      hard_s2_q <= 1'b1;
      hard_s3_q <= 1'b1;
      soft_s1_q <= 1'b1;
      soft_s2_q <= 1'b1;
      soft_s3_q <= 1'b1;
      strap_s1_q <= {`RCS_STRAP_W{1'b0}};
      strap_s2_q <= {`RCS_STRAP_W{1'b0}};
    end else begin
      por_s1_q <= power_on_reset_in;
      por_s2_q <= por_s1_q;
      por_s3_q <= por_s2_q;
      lock_s1_q <= system_pll_lock;
      lock_s2_q <= lock_s1_q;
      hard_s1_q <= hard_reset_line_in;
      hard_s2_q <= hard_s1_q;
      hard_s3_q <= hard_s2_q;
      soft_s1_q <= soft_reset_line_in;
      soft_s2_q <= soft_s1_q;
      soft_s3_q <= soft_s2_q;
      strap_s1_q <= strap_in;
      strap_s2_q <= strap_s1_q;
    end
  end
  wire por_release = por_s2_q & ~por_s3_q;
  wire hard_fall = hard_s3_q & ~hard_s2_q;
  wire soft_fall = soft_s3_q & ~soft_s2_q;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  reg [2:0] state_q, state_d;
  reg por_flow_q;
  reg pll_tmo_q;
  reg cfg_default_q;
  reg fetch_done_q;
  wire [CNT_W-1:0] cnt;

  cycle_counter #(.CNT_W(CNT_W)) u_cnt (
    .clk(clk),
    .reset(reset),
    .clear(state_d != state_q),
    .count_q(cnt)
  );

  always @* begin
    state_d = state_q;
    case (state_q)
      S_POR: begin
        if (por_release) begin // [RULE1]
          state_d = S_HOLD;
        end
      end
      S_HOLD: begin
        if (cnt == POR_LAST) begin // [RULE2]
          state_d = S_PLL;
        end
      end
      S_PLL: begin
        if (lock_s2_q) begin
          state_d = S_REL;
        end
      end
      S_REL: begin
        if (cnt == SOFT_LAST) begin // [RULE5]
          state_d = S_RUN;
        end
      end
      S_RUN: begin
        if (hard_fall) begin
          state_d = S_REL;
        end else if (soft_fall) begin // [RULE11]
          state_d = S_SOFT;
        end
      end
      S_SOFT: begin
        if (cnt == EXT_LAST) begin
          state_d = S_RUN;
        end
      end
      default: begin
        state_d = S_POR;
      end
    endcase
    if (~por_s2_q) begin
      state_d = S_POR;
    end
  end

  wire hard_drive = (state_q == S_POR) || (state_q == S_HOLD) || (state_q == S_PLL) ||
                    ((state_q == S_REL) && (cnt < HARD_LAST)); // [RULE4] [RULE13]
  wire soft_drive = hard_drive || ((state_q == S_REL) && (cnt < SOFT_LAST)) || (state_q == S_SOFT); // [RULE10] [RULE5]
  wire cfg_open = (state_q != S_RUN) && (state_q != S_SOFT);
  wire dsi_ok = cfg_open && por_flow_q && strap_q[`RCS_SP_SOURCE]; // [RULE7] [RULE12]
  wire bus_ok = cfg_open && ~strap_q[`RCS_SP_SOURCE]; // [RULE7] [RULE12]
  wire acc = psel && penable && pready;
  wire dsi_wr = acc && pwrite && (paddr == `RCS_DSI_CFG_OFS) && dsi_ok;
  wire bus_wr = sysbus_cfg_valid && bus_ok && ~cfg_valid_q;
  wire tmo_clr = acc && pwrite && (paddr == `RCS_STATUS_OFS) && pwdata[`RCS_ST_PLL_TMO];

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= S_POR;
      por_flow_q <= 1'b1;
      pll_tmo_q <= 1'b0;
      cfg_default_q <= 1'b0;
      fetch_done_q <= 1'b0;
      internal_por_q <= 1'b1;
      strap_q <= {`RCS_STRAP_W{1'b0}};
      cfg_word_q <= `RCS_DEFAULT_CFG;
      cfg_valid_q <= 1'b0;
      cfg_fetch_q <= 1'b0;
      hard_reset_line_out <= 1'b0;
      hard_reset_line_oe <= 1'b1;
      soft_reset_line_out <= 1'b0;
      soft_reset_line_oe <= 1'b1;
    end else begin
      state_q <= state_d;
      hard_reset_line_out <= 1'b0;
      soft_reset_line_out <= 1'b0;
      hard_reset_line_oe <= hard_drive;
      soft_reset_line_oe <= soft_drive;
      internal_por_q <= (state_q == S_POR) || (state_q == S_HOLD);
      if (por_release) begin
        strap_q <= strap_s2_q; // [RULE6]
      end
      if (state_q == S_POR) begin
        por_flow_q <= 1'b1;
        cfg_valid_q <= 1'b0;
        cfg_default_q <= 1'b0;
        fetch_done_q <= 1'b0;
      end else if ((state_q == S_RUN) && hard_fall) begin
        por_flow_q <= 1'b0;
        cfg_valid_q <= 1'b0;
        cfg_default_q <= 1'b0;
        fetch_done_q <= 1'b0;
      end else if (dsi_wr) begin
        cfg_word_q <= pwdata;
        cfg_valid_q <= 1'b1;
      end else if (bus_wr) begin
        cfg_word_q <= sysbus_cfg_word; // [RULE8]
        cfg_valid_q <= 1'b1;
      end else if ((state_q == S_REL) && (cnt == HARD_LAST) && ~cfg_valid_q) begin
        cfg_word_q <= `RCS_DEFAULT_CFG; // [RULE9]
        cfg_valid_q <= 1'b1;
        cfg_default_q <= 1'b1;
      end
      cfg_fetch_q <= 1'b0;
      if (bus_ok && strap_q[`RCS_SP_ROLE] && ~fetch_done_q && (state_q == S_REL)) begin
        cfg_fetch_q <= 1'b1; // [RULE8]
        fetch_done_q <= 1'b1;
      end
      if ((state_q == S_PLL) && (cnt == PLL_LAST) && ~lock_s2_q) begin
        pll_tmo_q <= 1'b1; // [RULE3]
      end else if (tmo_clr) begin
        pll_tmo_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // apb slave, one wait state
  // ----------------------------------------
  reg [31:0] rdata_d;
  reg hit_d;
  always @* begin
    rdata_d = 32'h00000000;
    hit_d = 1'b1;
    case (paddr)
      `RCS_STATUS_OFS: begin
        rdata_d[`RCS_ST_STATE_LSB+2:`RCS_ST_STATE_LSB] = state_q;
        rdata_d[`RCS_ST_PLL_TMO] = pll_tmo_q;
        rdata_d[`RCS_ST_CFG_VALID] = cfg_valid_q;
        rdata_d[`RCS_ST_CFG_DEFAULT] = cfg_default_q;
        rdata_d[`RCS_ST_POR_FLOW] = por_flow_q;
        rdata_d[`RCS_ST_HARD] = hard_reset_line_oe;
        rdata_d[`RCS_ST_SOFT] = soft_reset_line_oe;
      end
      `RCS_STRAPS_OFS: begin
        rdata_d[`RCS_STRAP_W-1:0] = strap_q;
      end
      `RCS_CFG_WORD_OFS, `RCS_DSI_CFG_OFS: begin
        rdata_d = cfg_word_q;
      end
      default: begin
        hit_d = 1'b0;
      end
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && penable && ~pready) begin
      pready <= 1'b1;
      pslverr <= ~hit_d;
      prdata <= pwrite ? 32'h00000000 : rdata_d;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end
endmodule // reset_config_sequencer

// [rcs_checker.sv]
// assertions on the sequencer ports
// assumes the bind below onto reset_config_sequencer
`timescale 1ns/1ps
module rcs_checker #(
  parameter POR_HOLD_CYC = 8
) (
  input wire clk,
  input wire reset,
  input wire power_on_reset_in,
  input wire [13:0] strap_in,
  input wire system_pll_lock,
  input wire hard_reset_line_oe,
  input wire soft_reset_line_oe,
  input wire internal_por_q,
  input wire [13:0] strap_q,
  input wire [31:0] cfg_word_q,
  input wire cfg_valid_q,
  input wire cfg_fetch_q,
  input wire sysbus_cfg_valid,
  input wire [31:0] sysbus_cfg_word
);
  // ----------------------------------------
  // helper counters and checks
  // ----------------------------------------
  reg [15:0] por_cnt_q;
  reg [15:0] rel_cnt_q;
  reg [31:0] bus_w_q;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      por_cnt_q <= 16'h0;
      rel_cnt_q <= 16'h0;
      bus_w_q <= 32'h0;
    end else begin
      por_cnt_q <= (power_on_reset_in && internal_por_q) ? por_cnt_q + 16'h1 : 16'h0;
      rel_cnt_q <= hard_reset_line_oe ? rel_cnt_q + {15'h0, system_pll_lock} : 16'h0;
      if (sysbus_cfg_valid) bus_w_q <= sysbus_cfg_word;
    end
  end
  hard_soft_tie_a: assert property (hard_reset_line_oe |-> soft_reset_line_oe)
    else $error("soft line idle while hard line driven");
  por_hold_a: assert property ($fell(internal_por_q) |->
    por_cnt_q >= POR_HOLD_CYC + 1 && por_cnt_q <= POR_HOLD_CYC + 6) else $error("internal reset hold wrong");
  por_drive_a: assert property (internal_por_q |-> hard_reset_line_oe && soft_reset_line_oe)
    else $error("lines released during internal reset");
  hard_rel_a: assert property ($fell(hard_reset_line_oe) |-> rel_cnt_q >= 509 && rel_cnt_q <= 516)
    else $error("hard release count wrong");
  soft_rel_a: assert property ($fell(hard_reset_line_oe) |->
    soft_reset_line_oe [*3] ##1 !soft_reset_line_oe) else $error("soft release not three later");
  strap_cap_a: assert property ($fell(internal_por_q) |-> strap_q == strap_in)
    else $error("straps not captured");
  bus_cfg_a: assert property (sysbus_cfg_valid && !strap_q[0] && !cfg_valid_q && !internal_por_q &&
    hard_reset_line_oe |-> ##[1:2] cfg_valid_q && cfg_word_q == bus_w_q) else $error("bus word not taken");
  fetch_role_a: assert property (cfg_fetch_q |-> strap_q[1] && hard_reset_line_oe ##1 !cfg_fetch_q)
    else $error("fetch outside master role");
  cfg_default_a: assert property ($fell(soft_reset_line_oe) && !hard_reset_line_oe |-> cfg_valid_q)
    else $error("no config applied at release");
endmodule // rcs_checker
bind reset_config_sequencer rcs_checker #(.POR_HOLD_CYC(POR_HOLD_CYC)) u_chk (.clk, .reset, .power_on_reset_in,
  .strap_in, .system_pll_lock, .hard_reset_line_oe, .soft_reset_line_oe, .internal_por_q, .strap_q,
  .cfg_word_q, .cfg_valid_q, .cfg_fetch_q, .sysbus_cfg_valid, .sysbus_cfg_word);

// [board_model.sv]
// board reset logic, pll and open-drain reset lines
// assumes por_req and line pulls come from the bench on clk
`timescale 1ns/1ps
module board_model #(
  parameter LOCK_DLY = 12
) (
  input wire clk,
  input wire por_req,
  input wire internal_por_q,
  input wire hard_oe,
  input wire soft_oe,
  input wire hard_pull,
  input wire soft_pull,
  input wire lock_hold,
  output logic power_on_reset_in,
  output logic system_pll_lock,
  output wire hard_line,
  output wire soft_line
);
  // ----------------------------------------
  // pins
  // ----------------------------------------
  int low_cnt = 0;
  int lock_cnt = 0;
  assign hard_line = !(hard_oe || hard_pull);
  assign soft_line = !(soft_oe || soft_pull);
  initial begin
    power_on_reset_in = 1'b0;
    system_pll_lock = 1'b0;
  end
  always @(posedge clk) begin
    low_cnt <= power_on_reset_in ? 0 : low_cnt + 1;
    if (por_req) power_on_reset_in <= 1'b0;
    else if (low_cnt >= 16) power_on_reset_in <= 1'b1;
    lock_cnt <= (internal_por_q || !power_on_reset_in) ? 0 : lock_cnt + 1;
    system_pll_lock <= (lock_cnt >= LOCK_DLY) && !lock_hold;
  end
endmodule // board_model

// [reset_config_sequencer_tb_top.sv]
// self-checking bench for the reset and configuration sequencer
// assumes the board model and the bound checker
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", nm, e, s); end end
module reset_config_sequencer_tb_top;
  // ----------------------------------------
  // bench
  // ----------------------------------------
  logic clk, reset, por_req, hard_pull, soft_pull, sysbus_cfg_valid, psel, penable, pwrite, er, lock_hold;
  logic power_on_reset_in, system_pll_lock, hard_line, soft_line, hard_oe, soft_oe;
  logic internal_por_q, cfg_valid_q, cfg_fetch_q, pready, pslverr;
  logic [13:0] strap_in, strap_q, straps;
  logic [31:0] sysbus_cfg_word, cfg_word_q, pwdata, prdata, word, rd;
  logic [7:0] paddr;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  reset_config_sequencer #(.POR_HOLD_CYC(8), .PLL_LOCK_CYC(20)) u_dut (.clk, .reset, .power_on_reset_in,
    .strap_in, .system_pll_lock, .hard_reset_line_in(hard_line), .hard_reset_line_out(),
    .hard_reset_line_oe(hard_oe), .soft_reset_line_in(soft_line), .soft_reset_line_out(),
    .soft_reset_line_oe(soft_oe), .internal_por_q, .strap_q, .cfg_word_q, .cfg_valid_q, .cfg_fetch_q,
    .sysbus_cfg_valid, .sysbus_cfg_word, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  board_model u_board (.clk, .por_req, .internal_por_q, .hard_oe, .soft_oe, .hard_pull, .soft_pull, .lock_hold,
    .power_on_reset_in, .system_pll_lock, .hard_line, .soft_line);
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report;
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  task automatic bus_write(input logic [31:0] w);
    sysbus_cfg_valid <= 1; sysbus_cfg_word <= w;
    @(posedge clk);
    sysbus_cfg_valid <= 0;
  endtask
  task automatic pull(input logic h);
    if (h) hard_pull <= 1; else soft_pull <= 1;
    repeat (3) @(posedge clk);
    hard_pull <= 0; soft_pull <= 0;
    repeat (2) @(posedge clk);
  endtask
  initial begin
    reset = 1; por_req = 1; hard_pull = 0; soft_pull = 0; sysbus_cfg_valid = 0; sysbus_cfg_word = 0;
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; strap_in = 0; lock_hold = 0;
    repeat (2) @(posedge clk);
    reset <= 0;
    word = $urandom(32'h5bf4);
    for (int t = 0; t < 3; t++) begin
      straps = $urandom;
      straps[1:0] = (t == 0) ? 2'b01 : (t == 1) ? 2'b00 : 2'b10;
      por_req <= 1; strap_in <= straps; lock_hold <= (t == 1);
      repeat (8) @(posedge clk);
      por_req <= 0;
      do @(posedge clk); while (internal_por_q !== 1'b0);
      strap_in <= ~straps;
      `CHK("strap_q", straps, strap_q)
      if (t == 1) begin
        repeat (30) @(posedge clk);
        apb(0, 8'h00, 0);
        `CHK("pll_tmo", 4'hA, {rd[4], rd[2:0]})
        apb(1, 8'h00, 32'h00000010);
        apb(0, 8'h00, 0);
        `CHK("tmo_clr", 1'b0, rd[4])
        lock_hold <= 0;
      end
      word = $urandom;
      if (t == 0) begin
        bus_write(~word);
        apb(1, 8'h0C, word);
      end
      if (t == 1) word = 32'h00000000;
      if (t == 2) begin
        do @(posedge clk); while (cfg_fetch_q !== 1'b1);
        bus_write(word);
      end
      do @(posedge clk); while (soft_oe !== 1'b0);
      `CHK("hard_oe", 1'b0, hard_oe)
      apb(0, 8'h08, 0);
      `CHK("cfg_word", word, rd)
      apb(1, 8'h0C, ~word);
      apb(0, 8'h0C, 0);
      `CHK("cfg_locked", word, rd)
      $display("test %0d done", t);
    end
    apb(0, 8'h10, 0);
    `CHK("unmapped_err", 1'b1, er)
    pull(0);
    `CHK("soft_ext", 2'b01, {hard_oe, soft_oe})
    do @(posedge clk); while (soft_oe !== 1'b0);
    pull(1);
    `CHK("hard_ext", 2'b11, {hard_oe, soft_oe})
    do @(posedge clk); while (soft_oe !== 1'b0);
    $display("test ext done");
    final_report;
  end
endmodule // reset_config_sequencer_tb_top
